// ---- rlsq_pkg.sv ----
// Purpose: Shared constants and types for the reset level sequencer.
// Assumes: CLOCK runs at 125 MHz.
// Notes: Level codes match the software reset command encoding.
package rlsq_pkg;

  // Clock rate and reset pin timing.
  localparam int unsigned RLSQ_CLOCK_HZ = 125_000_000;
  localparam int unsigned RLSQ_PIN_POR_TIME_MS = 1000;
  localparam int unsigned RLSQ_PIN_POR_CYCLES = (RLSQ_CLOCK_HZ / 1000) * RLSQ_PIN_POR_TIME_MS;
  localparam int unsigned RLSQ_PIN_MIN_PULSE_NS = 1000;
  localparam int unsigned RLSQ_PIN_MIN_CYCLES = (RLSQ_PIN_MIN_PULSE_NS * (RLSQ_CLOCK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RLSQ_PIN_CNT_W = 27;

  // Last hold count; each timed reset level is held one cycle longer than this before it cascades.
  localparam logic [2:0] RLSQ_HOLD_LAST = 3'h3;

  // Boot routine attempts before lockout.
  localparam logic [1:0] RLSQ_BOOT_TRIES = 2'h3;

  // Software level codes and command key.
  localparam logic [1:0] RLSQ_LVL_SYS = 2'h0;
  localparam logic [1:0] RLSQ_LVL_BOOT = 2'h1;
  localparam logic [1:0] RLSQ_LVL_SYS_BSL = 2'h2;
  localparam logic [1:0] RLSQ_LVL_POR = 2'h3;
  localparam logic [7:0] RLSQ_CMD_KEY = 8'he4;

  // Operating modes.
  localparam logic [1:0] RLSQ_MODE_RUN = 2'h0;

  // Width ranks of the levels.
  localparam logic [2:0] RLSQ_RANK_NONE = 3'h0;
  localparam logic [2:0] RLSQ_RANK_CPU = 3'h1;
  localparam logic [2:0] RLSQ_RANK_SYS = 3'h2;
  localparam logic [2:0] RLSQ_RANK_BOOT = 3'h3;
  localparam logic [2:0] RLSQ_RANK_BOR = 3'h4;
  localparam logic [2:0] RLSQ_RANK_POR = 3'h5;

  // Synchroniser lanes and their reset value; the pin lane idles high.
  localparam int unsigned RLSQ_SYNC_W = 6;
  localparam int unsigned RLSQ_SY_PIN = 0;
  localparam int unsigned RLSQ_SY_PORMON = 1;
  localparam int unsigned RLSQ_SY_BOR0F = 2;
  localparam int unsigned RLSQ_SY_BOR0R = 3;
  localparam int unsigned RLSQ_SY_WDT0 = 4;
  localparam int unsigned RLSQ_SY_CLKF = 5;
  localparam logic [5:0] RLSQ_SYNC_RST = 6'h01;

  typedef enum logic [8:0] {
    RLSQ_S_POR = 9'h001,
    RLSQ_S_BOR = 9'h002,
    RLSQ_S_BORW = 9'h004,
    RLSQ_S_BOOT = 9'h008,
    RLSQ_S_BRUN = 9'h010,
    RLSQ_S_LOCK = 9'h020,
    RLSQ_S_SYS = 9'h040,
    RLSQ_S_CPU = 9'h080,
    RLSQ_S_RUN = 9'h100
  } rlsq_state_t;

  typedef struct packed {
    rlsq_state_t state;
    logic [2:0] hold;
    logic [1:0] tries;
    logic [1:0] level;
    logic keep_lf;
    logic keep_io;
    logic pin_en;
    logic dbg_en;
    logic [1:0] mode;
    logic [RLSQ_PIN_CNT_W-1:0] pin_cnt;
    logic pin_por_done;
    logic [RLSQ_SYNC_W-1:0] sync1;
    logic [RLSQ_SYNC_W-1:0] sync2;
  } rlsq_regs_t;

endpackage

// ---- rlsq_top.sv ----
// Purpose: Gathers reset sources and walks the cascade of reset levels.
// Assumes: Boot routine reports done or fail; software command pulses are one cycle.
// Notes: Reset outputs are decoded from the registered state, active high.
`timescale 1ns/100ps

module rlsq_top
  import rlsq_pkg::*;
#(
  parameter int unsigned PIN_POR_CYCLES = RLSQ_PIN_POR_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic RESET_PIN_N,
  input wire logic POR_MON_FAULT,
  input wire logic PMU_TRIM_PARITY_ERR,
  input wire logic SHDN_STORE_PARITY_ERR,
  input wire logic FIRST_BROWNOUT_MONITOR_FALL,
  input wire logic FIRST_BROWNOUT_MONITOR_ABOVE_RISE,
  input wire logic SHDN_EXIT_WAKE,
  input wire logic SHDN_EXIT_PIN,
  input wire logic SHDN_EXIT_DEBUG,
  input wire logic TRIM_PARITY_ERR,
  input wire logic CLK_FATAL,
  input wire logic WDT0_VIOL,
  input wire logic SYS_RST_REQ,
  input wire logic CPU_RST_REQ,
  input wire logic LEVEL_WR,
  input wire logic [1:0] LEVEL_WDATA,
  input wire logic CMD_GO,
  input wire logic [7:0] CMD_KEY,
  input wire logic PIN_DISABLE,
  input wire logic DEBUG_DISABLE,
  input wire logic BOOT_DONE,
  input wire logic BOOT_FAIL,
  input wire logic MODE_REQ,
  input wire logic [1:0] MODE_SEL,
  input wire logic MODE_EXIT,
  output logic POR_ACTIVE,
  output logic PMU_RESET,
  output logic CORE_POWER_CYCLE,
  output logic BOOT_RESET,
  output logic SRAM_POWER_CYCLE,
  output logic FCL_RESET,
  output logic LF_CLOCK_RESET,
  output logic BOOT_ROUTINE_RUN,
  output logic SYSTEM_RESET,
  output logic PERIPH_RESET,
  output logic CPU_RESET,
  output logic SHDN_STORE_CLEAR,
  output logic KEEP_LATCHED_IO,
  output logic RESET_PIN_ENABLED,
  output logic DEBUG_PIN_ENABLED,
  output logic BOOT_LOCKED,
  output logic [1:0] BOOT_TRIES,
  output logic [1:0] LEVEL_SELECT,
  output logic [1:0] OP_MODE
);

  rlsq_regs_t st_q;
  rlsq_regs_t st_d;
  logic [RLSQ_SYNC_W-1:0] raw_in;
  logic pin_low;
  logic pin_por_hit;
  logic pin_short;
  logic sw_go;
  logic por_req;
  logic bor_req;
  logic boot_req;
  logic boot_keep_lf;
  logic sys_req;
  logic cpu_req;
  logic shdn_exit;
  logic [2:0] cur_rank;
  logic hold_done;
  logic lf_reset_level;
  logic sys_level;

  // Raw asynchronous sources; only the second stage is ever looked at.
  assign raw_in = {CLK_FATAL, WDT0_VIOL, FIRST_BROWNOUT_MONITOR_ABOVE_RISE, FIRST_BROWNOUT_MONITOR_FALL, POR_MON_FAULT, RESET_PIN_N};

  // Reset pin qualification uses the synchronised level only.
  assign pin_low = st_q.pin_en && !st_q.sync2[RLSQ_SY_PIN];
  assign pin_por_hit = pin_low && !st_q.pin_por_done
    && (st_q.pin_cnt == RLSQ_PIN_CNT_W'(PIN_POR_CYCLES - 1));
  assign pin_short = st_q.pin_en && st_q.sync2[RLSQ_SY_PIN] && !st_q.pin_por_done
    && (st_q.pin_cnt >= RLSQ_PIN_CNT_W'(RLSQ_PIN_MIN_CYCLES));

  // A command is taken only with the correct key; the level comes from the earlier write.
  assign sw_go = CMD_GO && (CMD_KEY == RLSQ_CMD_KEY);
  assign shdn_exit = SHDN_EXIT_WAKE || SHDN_EXIT_PIN || SHDN_EXIT_DEBUG;

  // Requests grouped by the level they call for.
  assign por_req = st_q.sync2[RLSQ_SY_PORMON] || PMU_TRIM_PARITY_ERR || SHDN_STORE_PARITY_ERR
    || (sw_go && st_q.level == RLSQ_LVL_POR) || pin_por_hit;
  assign bor_req = st_q.sync2[RLSQ_SY_BOR0F] || shdn_exit;
  assign boot_keep_lf = pin_short || st_q.sync2[RLSQ_SY_WDT0] || (sw_go && st_q.level == RLSQ_LVL_BOOT);
  assign boot_req = boot_keep_lf || TRIM_PARITY_ERR || st_q.sync2[RLSQ_SY_CLKF];
  assign sys_req = SYS_RST_REQ || (sw_go && (st_q.level == RLSQ_LVL_SYS || st_q.level == RLSQ_LVL_SYS_BSL));
  assign cpu_req = CPU_RST_REQ;
  assign hold_done = (st_q.hold == RLSQ_HOLD_LAST);

  // Width of the level in progress; lockout ranks as boot so only wider sources free it.
  always_comb
  begin
    case (st_q.state)
      RLSQ_S_POR: cur_rank = RLSQ_RANK_POR;
      RLSQ_S_BOR, RLSQ_S_BORW: cur_rank = RLSQ_RANK_BOR;
      RLSQ_S_BOOT, RLSQ_S_BRUN, RLSQ_S_LOCK: cur_rank = RLSQ_RANK_BOOT;
      RLSQ_S_SYS: cur_rank = RLSQ_RANK_SYS;
      RLSQ_S_CPU: cur_rank = RLSQ_RANK_CPU;
      default: cur_rank = RLSQ_RANK_NONE;
    endcase
  end

  // Next state of every register of the block.
  always_comb
  begin
    st_d = st_q;
    st_d.sync1 = raw_in;
    st_d.sync2 = st_q.sync1;
    if (st_q.hold != RLSQ_HOLD_LAST)
    begin
      st_d.hold = st_q.hold + 3'h1;
    end
    if (LEVEL_WR)
    begin
      st_d.level = LEVEL_WDATA;
    end
    if (PIN_DISABLE)
    begin
      st_d.pin_en = 1'b0;
    end
    if (DEBUG_DISABLE)
    begin
      st_d.dbg_en = 1'b0;
    end
    // Low-time counter saturates so a held pin fires power-on only once.
    if (pin_low)
    begin
      if (st_q.pin_cnt != RLSQ_PIN_CNT_W'(PIN_POR_CYCLES))
      begin
        st_d.pin_cnt = st_q.pin_cnt + RLSQ_PIN_CNT_W'(1);
      end
      if (pin_por_hit)
      begin
        st_d.pin_por_done = 1'b1;
      end
    end
    else
    begin
      st_d.pin_cnt = '0;
      st_d.pin_por_done = 1'b0;
    end
    // Cascade through the levels one after another.
    case (st_q.state)
      RLSQ_S_POR:
      begin
        st_d.pin_en = 1'b1;
        st_d.dbg_en = 1'b1;
        st_d.keep_io = 1'b0;
        if (hold_done)
        begin
          st_d.state = RLSQ_S_BOR;
          st_d.hold = '0;
        end
      end
      RLSQ_S_BOR:
      begin
        if (hold_done)
        begin
          st_d.state = RLSQ_S_BORW;
        end
      end
      RLSQ_S_BORW:
      begin
        // Boot waits for the supply; a stuck monitor holds the device here by design.
        if (st_q.sync2[RLSQ_SY_BOR0R])
        begin
          st_d.state = RLSQ_S_BOOT;
          st_d.hold = '0;
          st_d.tries = '0;
          st_d.keep_lf = 1'b0;
        end
      end
      RLSQ_S_BOOT:
      begin
        if (hold_done)
        begin
          st_d.state = RLSQ_S_BRUN;
        end
      end
      RLSQ_S_BRUN:
      begin
        if (BOOT_DONE)
        begin
          st_d.state = RLSQ_S_SYS;
          st_d.hold = '0;
          st_d.keep_io = 1'b0;
        end
        else if (BOOT_FAIL)
        begin
          if (st_q.tries == RLSQ_BOOT_TRIES - 2'h1)
          begin
            st_d.state = RLSQ_S_LOCK;
          end
          else
          begin
            st_d.state = RLSQ_S_BOOT;
            st_d.hold = '0;
            st_d.tries = st_q.tries + 2'h1;
          end
        end
      end
      RLSQ_S_LOCK:
      begin
        st_d.state = RLSQ_S_LOCK;
      end
      RLSQ_S_SYS, RLSQ_S_CPU:
      begin
        if (hold_done)
        begin
          st_d.state = RLSQ_S_RUN;
        end
      end
      RLSQ_S_RUN:
      begin
        // Low-power modes start from run and go back to it.
        if (MODE_EXIT)
        begin
          st_d.mode = RLSQ_MODE_RUN;
        end
        else if (MODE_REQ && st_q.mode == RLSQ_MODE_RUN)
        begin
          st_d.mode = MODE_SEL;
        end
      end
      default:
      begin
        st_d.state = RLSQ_S_POR;
        st_d.hold = '0;
      end
    endcase
    // Widest new request wins and restarts the cascade from its own level.
    if (por_req && cur_rank < RLSQ_RANK_POR)
    begin
      st_d.state = RLSQ_S_POR;
      st_d.hold = '0;
    end
    else if (bor_req && cur_rank < RLSQ_RANK_BOR)
    begin
      st_d.state = RLSQ_S_BOR;
      st_d.hold = '0;
      st_d.keep_io = shdn_exit && !st_q.sync2[RLSQ_SY_BOR0F];
    end
    else if (boot_req && cur_rank < RLSQ_RANK_BOOT)
    begin
      st_d.state = RLSQ_S_BOOT;
      st_d.hold = '0;
      st_d.tries = '0;
      st_d.keep_lf = boot_keep_lf && !TRIM_PARITY_ERR && !st_q.sync2[RLSQ_SY_CLKF];
    end
    else if (sys_req && cur_rank < RLSQ_RANK_SYS)
    begin
      st_d.state = RLSQ_S_SYS;
      st_d.hold = '0;
    end
    else if (cpu_req && cur_rank < RLSQ_RANK_CPU)
    begin
      st_d.state = RLSQ_S_CPU;
      st_d.hold = '0;
    end
    if (st_d.state != RLSQ_S_RUN)
    begin
      st_d.mode = RLSQ_MODE_RUN;
    end
  end

  // Single register stage; the clock enable freezes everything but the synchronous SYS_RST.
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      st_q.state <= RLSQ_S_POR;
      st_q.hold <= '0;
      st_q.tries <= '0;
      st_q.level <= RLSQ_LVL_SYS;
      st_q.keep_lf <= 1'b0;
      st_q.keep_io <= 1'b0;
      st_q.pin_en <= 1'b1;
      st_q.dbg_en <= 1'b1;
      st_q.mode <= RLSQ_MODE_RUN;
      st_q.pin_cnt <= '0;
      st_q.pin_por_done <= 1'b0;
      st_q.sync1 <= RLSQ_SYNC_RST;
      st_q.sync2 <= RLSQ_SYNC_RST;
    end
    else if (CLK_EN)
    begin
      st_q <= st_d;
    end
  end

  // Level outputs; each wider level also drives every narrower one.
  assign POR_ACTIVE = (st_q.state == RLSQ_S_POR);
  assign PMU_RESET = POR_ACTIVE || (st_q.state == RLSQ_S_BOR);
  assign CORE_POWER_CYCLE = PMU_RESET;
  assign BOOT_RESET = PMU_RESET || (st_q.state == RLSQ_S_BORW) || (st_q.state == RLSQ_S_BOOT);
  assign SRAM_POWER_CYCLE = BOOT_RESET;
  assign FCL_RESET = BOOT_RESET;
  assign lf_reset_level = BOOT_RESET && !((st_q.state == RLSQ_S_BOOT) && st_q.keep_lf);
  assign LF_CLOCK_RESET = lf_reset_level;
  assign BOOT_ROUTINE_RUN = (st_q.state == RLSQ_S_BRUN);
  assign sys_level = BOOT_RESET || BOOT_ROUTINE_RUN || (st_q.state == RLSQ_S_LOCK) || (st_q.state == RLSQ_S_SYS);
  assign SYSTEM_RESET = sys_level;
  assign PERIPH_RESET = sys_level;
  assign CPU_RESET = sys_level || (st_q.state == RLSQ_S_CPU);
  assign SHDN_STORE_CLEAR = POR_ACTIVE;
  assign KEEP_LATCHED_IO = st_q.keep_io && !POR_ACTIVE;
  assign RESET_PIN_ENABLED = st_q.pin_en;
  assign DEBUG_PIN_ENABLED = st_q.dbg_en;
  assign BOOT_LOCKED = (st_q.state == RLSQ_S_LOCK);
  assign BOOT_TRIES = st_q.tries;
  assign LEVEL_SELECT = st_q.level;
  assign OP_MODE = st_q.mode;

  sequence seq_sys_to_run;
    (st_q.state == RLSQ_S_SYS) ##[1:8] (st_q.state == RLSQ_S_RUN);
  endsequence

  sequence seq_por_to_bor;
    (st_q.state == RLSQ_S_POR) ##[1:8] (st_q.state == RLSQ_S_BOR);
  endsequence

  AST_POR_CASCADE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && POR_ACTIVE && hold_done && !$past(POR_ACTIVE, 4) && !por_req) |=> (st_q.state == RLSQ_S_BOR))
    else $error("Power-on did not cascade into brownout.");
  AST_POR_REENABLE: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && POR_ACTIVE && !PIN_DISABLE) |=> RESET_PIN_ENABLED)
    else $error("Power-on did not re-enable the reset pin.");
  AST_BOR_WAIT: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && st_q.state == RLSQ_S_BORW && !st_q.sync2[RLSQ_SY_BOR0R] && !por_req) |=> (st_q.state == RLSQ_S_BORW))
    else $error("Boot started below the rising threshold.");
  AST_BOOT_PASS: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && BOOT_ROUTINE_RUN && BOOT_DONE && !por_req && !bor_req) |=> seq_sys_to_run)
    else $error("Boot pass did not lead through system reset to run.");
  AST_BOOT_LOCK: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && BOOT_ROUTINE_RUN && BOOT_FAIL && !BOOT_DONE && st_q.tries == 2'h2 && !por_req && !bor_req)
    |=> BOOT_LOCKED)
    else $error("Third boot failure did not lock.");
  AST_LOCK_HOLDS: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && BOOT_LOCKED && !por_req && !bor_req) |=> BOOT_LOCKED)
    else $error("Lockout left without brownout or power-on.");
  // A frozen clock enable stalls the cascade, so the request only counts on an enabled edge.
  AST_WIDEST_FIRST: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && por_req && !POR_ACTIVE) |=> seq_por_to_bor)
    else $error("Power-on request did not take priority.");
  AST_CPU_ONLY: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && cpu_req && st_q.state == RLSQ_S_RUN && !por_req && !bor_req && !boot_req && !sys_req)
    |=> (st_q.state == RLSQ_S_CPU && CPU_RESET && !PERIPH_RESET))
    else $error("CPU-only reset touched peripherals.");
  AST_MODE_RUN: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (OP_MODE != RLSQ_MODE_RUN) |-> ($past(st_q.state) == RLSQ_S_RUN && st_q.state == RLSQ_S_RUN))
    else $error("Low-power mode outside run.");
  AST_PIN_LONG: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (CLK_EN && pin_por_hit) |=> POR_ACTIVE)
    else $error("Long reset pin hold did not raise power-on.");

endmodule

// ---- rlsq_far_model.sv ----
// Purpose: Far-side model of the boot routine and the first brownout monitor.
// Assumes: The boot routine answers only while the sequencer runs it.
// Notes: The bench sets the answer delay, pass or fail, and the supply level.
`timescale 1ns/100ps
module rlsq_far_model
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic ROUTINE_RUN,
  input wire logic FAIL_MODE,
  input wire logic [3:0] DELAY,
  input wire logic SUPPLY_LOW,
  output logic BOOT_DONE,
  output logic BOOT_FAIL,
  output logic FIRST_BROWNOUT_MONITOR_FALL,
  output logic FIRST_BROWNOUT_MONITOR_ABOVE_RISE
);
  logic [3:0] cnt_q;
  logic answered_q;

  // The falling violation and the rising threshold are two views of one supply level.
  assign FIRST_BROWNOUT_MONITOR_FALL = SUPPLY_LOW;
  assign FIRST_BROWNOUT_MONITOR_ABOVE_RISE = !SUPPLY_LOW;

  // One answer per run of the routine; a second pulse would look like a stray retry.
  always @(posedge CLOCK)
  begin
    BOOT_DONE <= 1'b0;
    BOOT_FAIL <= 1'b0;
    if (SYS_RST || !ROUTINE_RUN)
    begin
      cnt_q <= 4'h0;
      answered_q <= 1'b0;
    end
    else if (!answered_q && cnt_q == DELAY)
    begin
      BOOT_FAIL <= FAIL_MODE;
      BOOT_DONE <= !FAIL_MODE;
      answered_q <= 1'b1;
    end
    else if (!answered_q)
    begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// ---- rlsq_top_tb.sv ----
// Purpose: Self-checking bench for the reset level sequencer.
// Assumes: CLOCK at 125 MHz; the long pin count is shortened by parameter.
// Notes: Random delays, pulse lengths, keys and modes come from a fixed seed.
`timescale 1ns/100ps
module rlsq_top_tb;
  import rlsq_pkg::*;
  localparam int PIN_POR = 300;
  localparam logic [16:0] b_sys = 17'h00001, b_cpu = 17'h00002, b_lvl = 17'h00004, b_go = 17'h00008;
  localparam logic [16:0] b_pdis = 17'h00010, b_ddis = 17'h00020, b_mreq = 17'h00040, b_mexit = 17'h00080;
  localparam logic [16:0] b_wdt = 17'h10000;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic CLK_EN = 1'b1;
  logic RESET_PIN_N = 1'b1;
  logic [16:0] req = '0;
  logic [1:0] LEVEL_WDATA = 2'h0;
  logic [7:0] CMD_KEY = 8'h00;
  logic [1:0] MODE_SEL = 2'h0;
  logic fail_mode = 1'b0;
  logic [3:0] delay = 4'h0;
  logic supply_low = 1'b0;
  logic BOOT_DONE, BOOT_FAIL, FIRST_BROWNOUT_MONITOR_FALL, FIRST_BROWNOUT_MONITOR_ABOVE_RISE;
  logic POR_ACTIVE, PMU_RESET, CORE_POWER_CYCLE, BOOT_RESET, SRAM_POWER_CYCLE, FCL_RESET, LF_CLOCK_RESET;
  logic BOOT_ROUTINE_RUN, SYSTEM_RESET, PERIPH_RESET, CPU_RESET, SHDN_STORE_CLEAR, KEEP_LATCHED_IO;
  logic RESET_PIN_ENABLED, DEBUG_PIN_ENABLED, BOOT_LOCKED;
  logic [1:0] BOOT_TRIES, LEVEL_SELECT, OP_MODE;
  logic [16:0] src_tab [9] = '{17'h00800, 17'h01000, 17'h02000, 17'h04000, 17'h08000, b_wdt, 17'h00100,
    17'h00200, 17'h00400};
  int rk_tab [9] = '{3, 5, 5, 5, 3, 3, 4, 4, 4};
  int err_total = 0;
  int comparisons = 0;

  // Free-running clock, 8 ns period.
  always #4 CLOCK = ~CLOCK;

  rlsq_top #(.PIN_POR_CYCLES(PIN_POR)) DUT (
    .CLOCK, .SYS_RST, .CLK_EN, .RESET_PIN_N, .POR_MON_FAULT(req[12]), .PMU_TRIM_PARITY_ERR(req[13]),
    .SHDN_STORE_PARITY_ERR(req[14]), .FIRST_BROWNOUT_MONITOR_FALL, .FIRST_BROWNOUT_MONITOR_ABOVE_RISE, .SHDN_EXIT_WAKE(req[8]),
    .SHDN_EXIT_PIN(req[9]), .SHDN_EXIT_DEBUG(req[10]), .TRIM_PARITY_ERR(req[11]), .CLK_FATAL(req[15]),
    .WDT0_VIOL(req[16]), .SYS_RST_REQ(req[0]), .CPU_RST_REQ(req[1]), .LEVEL_WR(req[2]), .LEVEL_WDATA,
    .CMD_GO(req[3]), .CMD_KEY, .PIN_DISABLE(req[4]), .DEBUG_DISABLE(req[5]), .BOOT_DONE, .BOOT_FAIL,
    .MODE_REQ(req[6]), .MODE_SEL, .MODE_EXIT(req[7]), .POR_ACTIVE, .PMU_RESET, .CORE_POWER_CYCLE,
    .BOOT_RESET, .SRAM_POWER_CYCLE, .FCL_RESET, .LF_CLOCK_RESET, .BOOT_ROUTINE_RUN, .SYSTEM_RESET,
    .PERIPH_RESET, .CPU_RESET, .SHDN_STORE_CLEAR, .KEEP_LATCHED_IO, .RESET_PIN_ENABLED, .DEBUG_PIN_ENABLED,
    .BOOT_LOCKED, .BOOT_TRIES, .LEVEL_SELECT, .OP_MODE);

  rlsq_far_model far (
    .CLOCK, .SYS_RST, .ROUTINE_RUN(BOOT_ROUTINE_RUN), .FAIL_MODE(fail_mode), .DELAY(delay),
    .SUPPLY_LOW(supply_low), .BOOT_DONE, .BOOT_FAIL, .FIRST_BROWNOUT_MONITOR_FALL, .FIRST_BROWNOUT_MONITOR_ABOVE_RISE);

  // Which level is showing; each test of ranks 1 to 4 also demands that the next wider level is quiet.
  function automatic logic lvl_seen(input int r);
    case (r)
      5: lvl_seen = POR_ACTIVE;
      4: lvl_seen = PMU_RESET && !POR_ACTIVE;
      3: lvl_seen = BOOT_RESET && !PMU_RESET;
      2: lvl_seen = SYSTEM_RESET && !BOOT_RESET;
      1: lvl_seen = CPU_RESET && !SYSTEM_RESET;
      6: lvl_seen = BOOT_LOCKED;
      default: lvl_seen = !CPU_RESET;
    endcase
  endfunction

  // Level that a software command code should start.
  function automatic int cmd_rank(input int lv);
    return (lv == 3) ? 5 : (lv == 1) ? 3 : 2;
  endfunction

  task automatic final_report;
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      $display("Error %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      err_total++;
    end
  endtask

  // Every drive lands 1 ns after an edge, so outputs are settled when read.
  task automatic step(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  task automatic pulse(input logic [16:0] m);
    req <= m;
    step(1);
    req <= '0;
  endtask

  // A hang here ends the run through the closing report.
  task automatic wait_for(input int r, input int max);
    int i;
    for (i = 0; i < max && lvl_seen(r) !== 1'b1; i++)
      step(1);
    if (lvl_seen(r) !== 1'b1)
    begin
      $display("Error %0t: wait for level %0d timed out", $time, r);
      err_total++;
      final_report();
    end
  endtask

  task automatic sw_cmd(input int lv, input logic [7:0] key);
    LEVEL_WDATA <= 2'(lv);
    req <= b_lvl;
    step(1);
    CMD_KEY <= key;
    req <= b_go;
    step(1);
    req <= '0;
  endtask

  initial
  begin
    int i;
    int n;
    i = $urandom(26472);
    step(12);
    SYS_RST <= 1'b0;
    step(1);
    check({POR_ACTIVE, SHDN_STORE_CLEAR}, 2'h3, "cold start");
    wait_for(0, 120);
    check({RESET_PIN_ENABLED, DEBUG_PIN_ENABLED, BOOT_LOCKED, LEVEL_SELECT, OP_MODE}, {3'h6, 2'h0, RLSQ_MODE_RUN},
      "after boot");
    // Each hardware source must land on its own level and no wider.
    for (i = 0; i < 9; i++)
    begin
      delay <= 4'($urandom_range(0, 15));
      pulse(src_tab[i]);
      wait_for(rk_tab[i], 6);
      if (rk_tab[i] == 5) check(SHDN_STORE_CLEAR, 1, "store clear");
      if (rk_tab[i] == 4) check({CORE_POWER_CYCLE, KEEP_LATCHED_IO, SHDN_STORE_CLEAR}, 3'h6, "brownout");
      if (rk_tab[i] == 3)
        check({SRAM_POWER_CYCLE, FCL_RESET, CORE_POWER_CYCLE, LF_CLOCK_RESET}, {3'h6, src_tab[i] != b_wdt},
          "boot");
      wait_for(0, 120);
    end
    // All four software codes, answered two cycles after the level write.
    for (i = 0; i < 4; i++)
    begin
      sw_cmd(i, RLSQ_CMD_KEY);
      check(lvl_seen(cmd_rank(i)), 1, "command level");
      check(LEVEL_SELECT, i, "level select");
      if (i == 1) check(LF_CLOCK_RESET, 0, "lf kept");
      wait_for(0, 120);
    end
    sw_cmd(3, RLSQ_CMD_KEY ^ 8'($urandom_range(1, 255)));
    check(CPU_RESET, 0, "bad key");
    step(1);
    pulse(b_sys);
    check({lvl_seen(2), PERIPH_RESET}, 2'h3, "system start");
    step(3);
    check(SYSTEM_RESET, 1, "system held");
    step(1);
    check(CPU_RESET, 0, "system end");
    pulse(b_cpu);
    check({CPU_RESET, PERIPH_RESET, SYSTEM_RESET}, 3'h4, "cpu only");
    step(4);
    check(CPU_RESET, 0, "cpu end");
    pulse(b_sys | b_cpu | 17'h00800);
    check(lvl_seen(3), 1, "widest wins");
    wait_for(2, 12);
    check(BOOT_ROUTINE_RUN, 1, "routine runs");
    wait_for(0, 120);
    // Low-power modes: only from run, exit to run, a reset forces run.
    n = $urandom_range(1, 3);
    MODE_SEL <= 2'(n);
    pulse(b_mreq);
    check(OP_MODE, n, "mode enter");
    MODE_SEL <= 2'(n % 3 + 1);
    step(1);
    pulse(b_mreq);
    check(OP_MODE, n, "mode from mode");
    step(1);
    pulse(b_mexit);
    check(OP_MODE, RLSQ_MODE_RUN, "mode exit");
    step(1);
    pulse(b_mreq);
    step(1);
    pulse(b_sys);
    wait_for(0, 120);
    check(OP_MODE, RLSQ_MODE_RUN, "reset to run");
    // Reset pin: a short pulse is ignored, a medium one boots, a long one powers on.
    n = $urandom_range(20, 110);
    RESET_PIN_N <= 1'b0;
    step(n);
    RESET_PIN_N <= 1'b1;
    step(6);
    check(CPU_RESET, 0, "short pin");
    n = $urandom_range(140, 260);
    RESET_PIN_N <= 1'b0;
    step(n);
    RESET_PIN_N <= 1'b1;
    wait_for(3, 8);
    check(LF_CLOCK_RESET, 0, "pin boot lf");
    wait_for(0, 120);
    RESET_PIN_N <= 1'b0;
    step(PIN_POR - 10);
    check(CPU_RESET, 0, "pin not yet");
    wait_for(5, 20);
    RESET_PIN_N <= 1'b1;
    wait_for(0, 120);
    // Disabled pins survive boot and brownout, the lockout, and return on power-on.
    pulse(b_pdis);
    step(1);
    pulse(b_ddis);
    check({RESET_PIN_ENABLED, DEBUG_PIN_ENABLED}, 2'h0, "pins off");
    RESET_PIN_N <= 1'b0;
    step(150);
    RESET_PIN_N <= 1'b1;
    step(6);
    check(CPU_RESET, 0, "pin disabled");
    fail_mode <= 1'b1;
    sw_cmd(1, RLSQ_CMD_KEY);
    wait_for(6, 200);
    check(BOOT_TRIES, 2, "tries");
    check({RESET_PIN_ENABLED, DEBUG_PIN_ENABLED}, 2'h0, "boot keeps pins");
    pulse(b_sys);
    check(BOOT_LOCKED, 1, "lock holds");
    fail_mode <= 1'b0;
    supply_low <= 1'b1;
    step(12);
    check({BOOT_LOCKED, BOOT_RESET, BOOT_ROUTINE_RUN, PMU_RESET, KEEP_LATCHED_IO}, 5'h08,
      "waits for supply");
    supply_low <= 1'b0;
    wait_for(3, 8);
    wait_for(0, 120);
    check({RESET_PIN_ENABLED, DEBUG_PIN_ENABLED}, 2'h0, "brownout keeps pins");
    sw_cmd(3, RLSQ_CMD_KEY);
    wait_for(0, 120);
    check({RESET_PIN_ENABLED, DEBUG_PIN_ENABLED}, 2'h3, "power-on enables");
    // A frozen clock enable must hold a system reset well past its normal length.
    pulse(b_sys);
    CLK_EN <= 1'b0;
    step(8);
    check(SYSTEM_RESET, 1, "frozen");
    CLK_EN <= 1'b1;
    wait_for(0, 120);
    // A second reset in mid-run starts the cascade again from power-on.
    SYS_RST <= 1'b1;
    step(2);
    SYS_RST <= 1'b0;
    step(1);
    check({POR_ACTIVE, SHDN_STORE_CLEAR}, 2'h3, "mid-run reset");
    wait_for(0, 120);
    final_report();
  end
endmodule
